/* src/jbt_pkg.sv */
// constants, state type and decode helpers for the boundary-scan port
package jbt_pkg;
    localparam int unsigned BSR_LEN = 115;
    localparam int unsigned IR_LEN = 4;
    localparam int unsigned BSR_DIS_CELLS = 3;
    localparam int unsigned IN_SYNC_W = 4;
    // instruction codes, most significant bit first
    localparam logic [3:0] IR_EXTEST = 4'h0;
    localparam logic [3:0] IR_SAMPLE = 4'h1;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    // value parallel-loaded in capture-ir: upper bits zero, low bits 01
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    // no identification register here, so reset falls back to bypass
    localparam logic [3:0] IR_RESET = 4'hF;
    // sync vector bit positions
    localparam int unsigned IN_TCK = 0;
    localparam int unsigned IN_TMS = 1;
    localparam int unsigned IN_TDI = 2;
    localparam int unsigned IN_TRST = 3;
    localparam int unsigned TLR_TMS_COUNT = 5;

    typedef enum logic [3:0] {
        ST_TLR, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
        ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } jbt_state_e;

    // boundary register is selected by external test and sample/preload
    function automatic logic jbt_sel_bsr(input logic [3:0] ir);
        return (ir == IR_EXTEST) || (ir == IR_SAMPLE);
    endfunction
endpackage

/* src/jbt_tap_if.sv */
// carrier between the datapath and the tap state machine
interface jbt_tap_if;
    logic tck_rise;
    logic tms;
    logic trst_n;
    jbt_pkg::jbt_state_e state;

    modport fsm (input tck_rise, input tms, input trst_n, output state);
    modport core (output tck_rise, output tms, output trst_n, input state);
endinterface

/* src/jbt_sync.sv */
// two flip-flop synchroniser for a bundle of asynchronous levels
module jbt_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clock_i, // system clock
    input wire logic arst_n_i, // async reset, active low
    input wire logic [W-1:0] d_i, // asynchronous levels
    output logic [W-1:0] q_o // synchronised levels
);
    logic [W-1:0] meta_q;

    // first stage is read only by the second stage
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

/* src/jbt_tap_fsm.sv */
// sixteen-state test access port controller
module jbt_tap_fsm (
    input wire logic clock_i, // system clock
    input wire logic arst_n_i, // async reset, active low
    jbt_tap_if.fsm tap // edge, tms, reset in; state out
);
    logic [2:0] hi_cnt_q;

    // advance on each sampled rising tck edge; test reset wins
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tap.state <= jbt_pkg::ST_TLR;
        end else if (!tap.trst_n) begin
            tap.state <= jbt_pkg::ST_TLR;
        end else if (tap.tck_rise) begin
            unique case (tap.state)
                jbt_pkg::ST_TLR: tap.state <= tap.tms ? jbt_pkg::ST_TLR : jbt_pkg::ST_IDLE;
                jbt_pkg::ST_IDLE: tap.state <= tap.tms ? jbt_pkg::ST_SEL_DR : jbt_pkg::ST_IDLE;
                jbt_pkg::ST_SEL_DR: tap.state <= tap.tms ? jbt_pkg::ST_SEL_IR : jbt_pkg::ST_CAP_DR;
                jbt_pkg::ST_CAP_DR: tap.state <= tap.tms ? jbt_pkg::ST_EXIT1_DR : jbt_pkg::ST_SHIFT_DR;
                jbt_pkg::ST_SHIFT_DR: tap.state <= tap.tms ? jbt_pkg::ST_EXIT1_DR : jbt_pkg::ST_SHIFT_DR;
                jbt_pkg::ST_EXIT1_DR: tap.state <= tap.tms ? jbt_pkg::ST_UPD_DR : jbt_pkg::ST_PAUSE_DR;
                jbt_pkg::ST_PAUSE_DR: tap.state <= tap.tms ? jbt_pkg::ST_EXIT2_DR : jbt_pkg::ST_PAUSE_DR;
                jbt_pkg::ST_EXIT2_DR: tap.state <= tap.tms ? jbt_pkg::ST_UPD_DR : jbt_pkg::ST_SHIFT_DR;
                jbt_pkg::ST_UPD_DR: tap.state <= tap.tms ? jbt_pkg::ST_SEL_DR : jbt_pkg::ST_IDLE;
                jbt_pkg::ST_SEL_IR: tap.state <= tap.tms ? jbt_pkg::ST_TLR : jbt_pkg::ST_CAP_IR;
                jbt_pkg::ST_CAP_IR: tap.state <= tap.tms ? jbt_pkg::ST_EXIT1_IR : jbt_pkg::ST_SHIFT_IR;
                jbt_pkg::ST_SHIFT_IR: tap.state <= tap.tms ? jbt_pkg::ST_EXIT1_IR : jbt_pkg::ST_SHIFT_IR;
                jbt_pkg::ST_EXIT1_IR: tap.state <= tap.tms ? jbt_pkg::ST_UPD_IR : jbt_pkg::ST_PAUSE_IR;
                jbt_pkg::ST_PAUSE_IR: tap.state <= tap.tms ? jbt_pkg::ST_EXIT2_IR : jbt_pkg::ST_PAUSE_IR;
                jbt_pkg::ST_EXIT2_IR: tap.state <= tap.tms ? jbt_pkg::ST_UPD_IR : jbt_pkg::ST_SHIFT_IR;
                jbt_pkg::ST_UPD_IR: tap.state <= tap.tms ? jbt_pkg::ST_SEL_DR : jbt_pkg::ST_IDLE;
            endcase
        end
    end

    // helper: consecutive rising edges seen with tms high, saturating
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hi_cnt_q <= 3'h0;
        end else if (tap.tck_rise) begin
            if (!tap.tms) begin
                hi_cnt_q <= 3'h0;
            end else if (hi_cnt_q < 3'(jbt_pkg::TLR_TMS_COUNT)) begin
                hi_cnt_q <= hi_cnt_q + 3'h1;
            end
        end
    end

    property p_five_high;
        @(posedge clock_i) disable iff (!arst_n_i)
        hi_cnt_q == 3'(jbt_pkg::TLR_TMS_COUNT) |-> tap.state == jbt_pkg::ST_TLR;
    endproperty
    a_five_high: assert property (p_five_high) else $error("five tms highs did not reach reset");

    property p_trst;
        @(posedge clock_i) disable iff (!arst_n_i)
        !tap.trst_n |=> tap.state == jbt_pkg::ST_TLR;
    endproperty
    a_trst: assert property (p_trst) else $error("test reset did not reach reset state");

    property p_sel_ir;
        @(posedge clock_i) disable iff (!arst_n_i)
        tap.trst_n && tap.tck_rise && tap.state == jbt_pkg::ST_SEL_IR
        |=> tap.state == ($past(tap.tms) ? jbt_pkg::ST_TLR : jbt_pkg::ST_CAP_IR);
    endproperty
    a_sel_ir: assert property (p_sel_ir) else $error("bad exit from select-ir");

    property p_exit2_dr;
        @(posedge clock_i) disable iff (!arst_n_i)
        tap.trst_n && tap.tck_rise && tap.state == jbt_pkg::ST_EXIT2_DR
        |=> tap.state == ($past(tap.tms) ? jbt_pkg::ST_UPD_DR : jbt_pkg::ST_SHIFT_DR);
    endproperty
    a_exit2_dr: assert property (p_exit2_dr) else $error("bad exit from exit2-dr");

    property p_upd_dr;
        @(posedge clock_i) disable iff (!arst_n_i)
        tap.trst_n && tap.tck_rise && tap.state == jbt_pkg::ST_UPD_DR
        |=> tap.state == ($past(tap.tms) ? jbt_pkg::ST_SEL_DR : jbt_pkg::ST_IDLE);
    endproperty
    a_upd_dr: assert property (p_upd_dr) else $error("bad exit from update-dr");

    c_pause_ir: cover property (@(posedge clock_i) disable iff (!arst_n_i)
        tap.state == jbt_pkg::ST_PAUSE_IR);
endmodule

/* src/jbt_tap.sv */
// boundary-scan port: tck sampling, instruction, bypass and boundary registers

module jbt_tap (
    input wire logic clock_i, // system clock, 50 MHz
    input wire logic arst_n_i, // async reset, active low
    input wire logic tck_i, // test clock pin
    input wire logic tms_i, // test mode select pin
    input wire logic tdi_i, // test data in pin
    input wire logic trst_n_i, // test reset pin, active low
    input wire logic [114:0] pin_in_i, // pad levels, cell 1 at bit 0
    input wire logic [114:0] core_out_i, // values the core drives
    output logic tdo_o, // test data out
    output logic tdo_oe_o, // test data out enable
    output logic [114:0] pin_out_o, // values sent to pads
    output logic extest_o // pads under test control
);
    logic [3:0] in_s;
    logic [114:0] pin_s;
    logic tck_prev_q;
    logic [2:0] warm_q;
    logic tck_rise;
    logic tck_fall;
    logic tms_s;
    logic tdi_s;
    logic [3:0] ir_shift_q;
    logic [3:0] ir_q;
    logic byp_q;
    logic [114:0] bsr_shift_q;
    logic [114:0] bsr_upd_q;
    logic sel_bsr;
    jbt_pkg::jbt_state_e state;

    jbt_tap_if tap_if ();

    // pins come from another clock domain, so two flops each
    jbt_sync #(
        .W(jbt_pkg::IN_SYNC_W)
    ) u_sync_tap (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .d_i({trst_n_i, tdi_i, tms_i, tck_i}),
        .q_o(in_s)
    );

    jbt_sync #(
        .W(jbt_pkg::BSR_LEN)
    ) u_sync_pins (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .d_i(pin_in_i),
        .q_o(pin_s)
    );

    // sync and edge flop leave reset at 0 while tck may idle high;
    // edges are ignored until three clocks have refilled both stages
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            warm_q <= 3'h0;
        end else begin
            warm_q <= {warm_q[1:0], 1'b1};
        end
    end

    // tck edge finder on the synchronised level
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tck_prev_q <= 1'b0;
        end else begin
            tck_prev_q <= in_s[jbt_pkg::IN_TCK];
        end
    end

    assign tck_rise = warm_q[2] && in_s[jbt_pkg::IN_TCK] && !tck_prev_q;
    assign tck_fall = warm_q[2] && !in_s[jbt_pkg::IN_TCK] && tck_prev_q;
    assign tms_s = in_s[jbt_pkg::IN_TMS];
    assign tdi_s = in_s[jbt_pkg::IN_TDI];

    // controller sees edge, mode and test reset through the carrier
    assign tap_if.tck_rise = tck_rise;
    assign tap_if.tms = tms_s;
    assign tap_if.trst_n = in_s[jbt_pkg::IN_TRST];
    assign state = tap_if.state;

    jbt_tap_fsm u_fsm (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .tap(tap_if.fsm)
    );

    // reserved codes fall through to bypass
    assign sel_bsr = jbt_pkg::jbt_sel_bsr(ir_q);

    // instruction shift stage; lsb leaves first toward tdo
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ir_shift_q <= jbt_pkg::IR_CAPTURE;
        end else if (tck_rise) begin
            if (state == jbt_pkg::ST_CAP_IR) begin
                ir_shift_q <= jbt_pkg::IR_CAPTURE;
            end else if (state == jbt_pkg::ST_SHIFT_IR) begin
                ir_shift_q <= {tdi_s, ir_shift_q[3:1]};
            end
        end
    end

    // current instruction; only update-ir and reset touch it
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ir_q <= jbt_pkg::IR_RESET;
        end else if (state == jbt_pkg::ST_TLR) begin
            ir_q <= jbt_pkg::IR_RESET;
        end else if (tck_rise && state == jbt_pkg::ST_UPD_IR) begin
            ir_q <= ir_shift_q;
        end
    end

    // bypass stage has no parallel input, so capture leaves it alone
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            byp_q <= 1'b0;
        end else if (tck_rise && !sel_bsr && state == jbt_pkg::ST_SHIFT_DR) begin
            byp_q <= tdi_s;
        end
    end

    // boundary shift path: cell 1 is bit 0 next to tdi
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bsr_shift_q <= '0;
        end else if (tck_rise && sel_bsr) begin
            if (state == jbt_pkg::ST_CAP_DR) begin
                bsr_shift_q <= pin_s;
            end else if (state == jbt_pkg::ST_SHIFT_DR) begin
                bsr_shift_q <= {bsr_shift_q[113:0], tdi_s};
            end
        end
    end

    // update stage loads on falling tck in update-dr; test-logic-reset clears its top three cells
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bsr_upd_q <= '0;
        end else if (state == jbt_pkg::ST_TLR) begin
            // top cells act as enables; clearing them parks outputs
            bsr_upd_q[114:112] <= 3'h0;
        end else if (tck_fall && sel_bsr && state == jbt_pkg::ST_UPD_DR) begin
            bsr_upd_q <= bsr_shift_q;
        end
    end

    // tdo moves on falling tck so the tester samples a settled bit
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_o <= (state == jbt_pkg::ST_SHIFT_DR) || (state == jbt_pkg::ST_SHIFT_IR);
            if (state == jbt_pkg::ST_SHIFT_IR) begin
                tdo_o <= ir_shift_q[0];
            end else if (sel_bsr) begin
                tdo_o <= bsr_shift_q[114];
            end else begin
                tdo_o <= byp_q;
            end
        end
    end

    // pads follow the core unless external test owns them; one cycle late
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_out_o <= '0;
            extest_o <= 1'b0;
        end else begin
            extest_o <= (ir_q == jbt_pkg::IR_EXTEST);
            pin_out_o <= (ir_q == jbt_pkg::IR_EXTEST) ? bsr_upd_q : core_out_i;
        end
    end

    property p_cap_ir;
        @(posedge clock_i) disable iff (!arst_n_i)
        tck_rise && state == jbt_pkg::ST_CAP_IR |=> ir_shift_q == 4'h1;
    endproperty
    a_cap_ir: assert property (p_cap_ir) else $error("capture-ir value wrong");

    property p_shift_ir;
        @(posedge clock_i) disable iff (!arst_n_i)
        tck_rise && state == jbt_pkg::ST_SHIFT_IR
        |=> ir_shift_q == {$past(tdi_s), $past(ir_shift_q[3:1])};
    endproperty
    a_shift_ir: assert property (p_shift_ir) else $error("instruction shift wrong");

    property p_upd_ir;
        @(posedge clock_i) disable iff (!arst_n_i)
        tck_rise && state == jbt_pkg::ST_UPD_IR |=> ir_q == $past(ir_shift_q);
    endproperty
    a_upd_ir: assert property (p_upd_ir) else $error("instruction not taken in update-ir");

    property p_shift_dr;
        @(posedge clock_i) disable iff (!arst_n_i)
        tck_rise && sel_bsr && state == jbt_pkg::ST_SHIFT_DR
        |=> bsr_shift_q == {$past(bsr_shift_q[113:0]), $past(tdi_s)};
    endproperty
    a_shift_dr: assert property (p_shift_dr) else $error("boundary shift wrong");

    property p_cap_dr;
        @(posedge clock_i) disable iff (!arst_n_i)
        tck_rise && sel_bsr && state == jbt_pkg::ST_CAP_DR |=> bsr_shift_q == $past(pin_s);
    endproperty
    a_cap_dr: assert property (p_cap_dr) else $error("boundary capture wrong");

    property p_upd_dr_fall;
        @(posedge clock_i) disable iff (!arst_n_i)
        tck_fall && sel_bsr && state == jbt_pkg::ST_UPD_DR |=> bsr_upd_q == $past(bsr_shift_q);
    endproperty
    a_upd_dr_fall: assert property (p_upd_dr_fall) else $error("update-dr latch missed");

    property p_upd_hold;
        @(posedge clock_i) disable iff (!arst_n_i)
        state == jbt_pkg::ST_SHIFT_DR |=> $stable(bsr_upd_q);
    endproperty
    a_upd_hold: assert property (p_upd_hold) else $error("outputs moved while shifting");

    property p_pause;
        @(posedge clock_i) disable iff (!arst_n_i)
        state == jbt_pkg::ST_PAUSE_DR || state == jbt_pkg::ST_PAUSE_IR
        |=> $stable(bsr_shift_q) && $stable(ir_shift_q) && $stable(ir_q);
    endproperty
    a_pause: assert property (p_pause) else $error("registers moved in pause");

    property p_tdo_oe;
        @(posedge clock_i) disable iff (!arst_n_i)
        tck_fall |=> tdo_oe_o == ($past(state) == jbt_pkg::ST_SHIFT_DR || $past(state) == jbt_pkg::ST_SHIFT_IR);
    endproperty
    a_tdo_oe: assert property (p_tdo_oe) else $error("tdo enable wrong");

    property p_tdo_fall;
        @(posedge clock_i) disable iff (!arst_n_i)
        !tck_fall |=> $stable(tdo_o) && $stable(tdo_oe_o);
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off falling tck");

    property p_core_pins;
        @(posedge clock_i) disable iff (!arst_n_i)
        ir_q != jbt_pkg::IR_EXTEST |=> pin_out_o == $past(core_out_i);
    endproperty
    a_core_pins: assert property (p_core_pins) else $error("core lost the pins");

    property p_ext_pins;
        @(posedge clock_i) disable iff (!arst_n_i)
        ir_q == jbt_pkg::IR_EXTEST |=> pin_out_o == $past(bsr_upd_q) && extest_o;
    endproperty
    a_ext_pins: assert property (p_ext_pins) else $error("test pattern not on pins");

    property p_reserved;
        @(posedge clock_i) disable iff (!arst_n_i)
        tck_rise && state == jbt_pkg::ST_SHIFT_DR && !jbt_pkg::jbt_sel_bsr(ir_q) |=> byp_q == $past(tdi_s);
    endproperty
    a_reserved: assert property (p_reserved) else $error("bypass not on path");

    property p_tlr;
        @(posedge clock_i) disable iff (!arst_n_i)
        state == jbt_pkg::ST_TLR |=> ir_q == jbt_pkg::IR_RESET && bsr_upd_q[114:112] == 3'h0;
    endproperty
    a_tlr: assert property (p_tlr) else $error("reset state left instruction or output cells");

    property p_tdo_byp;
        @(posedge clock_i) disable iff (!arst_n_i)
        tck_fall && !sel_bsr && state == jbt_pkg::ST_SHIFT_DR |=> tdo_o == $past(byp_q);
    endproperty
    a_tdo_byp: assert property (p_tdo_byp) else $error("bypass stage not on tdo");

    c_extest: cover property (@(posedge clock_i) disable iff (!arst_n_i)
        extest_o && tck_fall && state == jbt_pkg::ST_UPD_DR);
    c_sample: cover property (@(posedge clock_i) disable iff (!arst_n_i)
        ir_q == jbt_pkg::IR_SAMPLE && tck_rise && state == jbt_pkg::ST_CAP_DR);
    c_bypass: cover property (@(posedge clock_i) disable iff (!arst_n_i)
        ir_q == jbt_pkg::IR_BYPASS && tck_rise && state == jbt_pkg::ST_SHIFT_DR);
endmodule

/* tb/jbt_tstr.sv */
// board-side test controller model: makes tck, drives tms, tdi and trst, reads tdo
module jbt_tstr (
    input wire logic clock_i, // bench clock that paces the link
    input wire logic tdo_i, // test data out of the port
    input wire logic tdo_oe_i, // drive enable of test data out
    output logic tck_o, // test clock, still between frames
    output logic tms_o, // test mode select
    output logic tdi_o, // test data in
    output logic trst_n_o, // test reset, active low
    output logic res_v_o, // one-cycle strobe: a bit was sampled
    output logic [1:0] res_o // sampled {enable, data line}
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_q = 1'b0;
    logic line;
    // a released line shows the inverse of the last driven bit, so a stale copy cannot pass
    always @(posedge clock_i) if (tdo_oe_i) last_q <= tdo_i;
    assign line = tdo_oe_i ? tdo_i : ~last_q;
    // idle levels: tck parked high, port held in reset until the bench lets go
    initial begin
        tck_o = 1'b1;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        trst_n_o = 1'b0;
        res_v_o = 1'b0;
        res_o = 2'b00;
    end
    // one tck period of 160 ns: move tms and tdi with the fall, read the line just before the rise
    task automatic step(input logic tms, input logic tdi);
        @(posedge clock_i);
        #1;
        tck_o = 1'b0;
        tms_o = tms;
        tdi_o = tdi;
        repeat (4) @(posedge clock_i);
        #1;
        res_o = {tdo_oe_i, line};
        res_v_o = 1'b1;
        tck_o = 1'b1;
        @(posedge clock_i);
        #1;
        res_v_o = 1'b0;
        repeat (2) @(posedge clock_i);
    endtask
    // pulse test reset; longer than the port's synchroniser needs
    task automatic trst();
        @(posedge clock_i);
        #1;
        trst_n_o = 1'b0;
        repeat (4) @(posedge clock_i);
        #1;
        trst_n_o = 1'b1;
        repeat (4) @(posedge clock_i);
    endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the boundary-scan port
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i;
    logic arst_n;
    logic tck, tms, tdi, trst_n, tdo, tdo_oe, extest, res_v;
    logic [1:0] res;
    logic [114:0] pin_in, core_out, pin_out, pin_hold, cap, p, q, d;
    logic [2:0] e;
    logic [3:0] code;
    logic [31:0] r;
    logic [2:0] exp_q[$];
    integer seed;
    int n_mismatch = 0;
    int tests_run = 0;

    jbt_tap dut (.clock_i(clock_i), .arst_n_i(arst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .trst_n_i(trst_n), .pin_in_i(pin_in), .core_out_i(core_out), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
        .pin_out_o(pin_out), .extest_o(extest));
    jbt_tstr u_tst (.clock_i(clock_i), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms),
        .tdi_o(tdi), .trst_n_o(trst_n), .res_v_o(res_v), .res_o(res));

    // 50 MHz system clock
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    task automatic end_sim();
        if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // bit 2 of a note says whether the data bit matters; the enable is always checked
    task automatic chk_tdo(input logic [2:0] ex, input logic [1:0] g);
        tests_run++;
        if (g[1] !== ex[1] || (ex[2] && g[0] !== ex[0])) begin
            n_mismatch++;
            $display("MISMATCH tdo exp %b got %b", ex, g);
        end
    endtask
    task automatic chk(input string name, input logic [114:0] ex, input logic [114:0] g);
        tests_run++;
        if (g !== ex) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", name, ex, g);
        end
    endtask

    // oldest note against each sampled tdo bit
    always @(posedge clock_i) if (res_v) begin
        e = exp_q.pop_front();
        chk_tdo(e, res);
    end

    function automatic logic [114:0] rnd();
        logic [127:0] v;
        for (int i = 0; i < 4; i++) v[32*i +: 32] = $random(seed);
        return v[114:0];
    endfunction

    task automatic tk(input logic t, input logic b, input logic [2:0] ex);
        exp_q.push_back(ex);
        u_tst.step(t, b);
    endtask

    // from idle: load an instruction lsb first, read back the captured value
    task automatic ir_load(input logic [3:0] c);
        tk(1'b1, 1'b0, 3'b000);
        tk(1'b1, 1'b0, 3'b000);
        tk(1'b0, 1'b0, 3'b000);
        tk(1'b0, 1'b0, 3'b000);
        for (int i = 0; i < 4; i++) begin
            tk(i == 1 || i == 3, c[i], {2'b11, jbt_pkg::IR_CAPTURE[i]});
            if (i == 1) begin
                tk(1'b0, 1'b0, 3'b000);
                tk(1'b1, 1'b0, 3'b000);
                tk(1'b0, 1'b0, 3'b000);
            end
        end
        tk(1'b1, 1'b0, 3'b000);
        tk(1'b0, 1'b0, 3'b000);
        repeat (8) @(posedge clock_i);
        #1;
    endtask

    // from idle: n-bit data scan with a pause after bit pz; pins checked while parked
    task automatic dr_scan(input int n, input logic [114:0] din, input logic [114:0] exo, input logic care0,
        input int pz);
        tk(1'b1, 1'b0, 3'b000);
        tk(1'b0, 1'b0, 3'b000);
        tk(1'b0, 1'b0, 3'b000);
        for (int i = 0; i < n; i++) begin
            tk(i == n - 1 || i == pz, din[n-1-i], {i > 0 || care0, 1'b1, exo[n-1-i]});
            if (i == pz) begin
                tk(1'b0, 1'b0, 3'b000);
                chk("pins_held", pin_hold, pin_out);
                tk(1'b1, 1'b0, 3'b000);
                tk(1'b0, 1'b0, 3'b000);
            end
        end
        tk(1'b1, 1'b0, 3'b000);
        tk(1'b0, 1'b0, 3'b000);
        repeat (8) @(posedge clock_i);
        #1;
    endtask

    // watchdog well beyond the roughly 58 us the sequence needs
    initial begin
        #400000;
        n_mismatch++;
        end_sim();
    end

    initial begin
        seed = 32'h279EBBE5;
        arst_n = 1'b0;
        pin_in = '0;
        core_out = '0;
        repeat (6) @(posedge clock_i);
        #1;
        arst_n = 1'b1;
        core_out = rnd();
        pin_hold = core_out;
        repeat (3) @(posedge clock_i);
        #1;
        chk("pins", core_out, pin_out);
        chk("extest", 115'(1'b0), 115'(extest));
        u_tst.trst();
        tk(1'b0, 1'b0, 3'b000);
        // bypass and one reserved code: both a single stage, core keeps the pins
        // the first bit out is what the bypass stage kept through capture
        d = '0;
        for (int k = 0; k < 2; k++) begin
            r = $random(seed);
            code = (k == 0) ? 4'hF : 4'h2 + 4'(r[3:0] % 4'hD);
            ir_load(code);
            q = d;
            d = rnd();
            dr_scan(8, d, {107'h0, q[0], d[7:1]}, 1'b1, 3);
            chk("pins", core_out, pin_out);
        end
        // sample/preload: capture pad levels, preload a pattern, core keeps the pins
        ir_load(4'h1);
        cap = rnd();
        pin_in = cap;
        p = rnd();
        dr_scan(115, p, cap, 1'b1, 60);
        chk("pins", core_out, pin_out);
        // external test: preloaded pattern drives the pins, then one capture/shift/update
        ir_load(4'h0);
        chk("extest", 115'(1'b1), 115'(extest));
        chk("pins", p, pin_out);
        pin_hold = p;
        cap = rnd();
        pin_in = cap;
        q = rnd();
        dr_scan(115, q, cap, 1'b1, 100);
        chk("pins", q, pin_out);
        // six tms-high rises from idle: reset reached on the third, then held
        for (int k = 0; k < 6; k++) tk(1'b1, 1'b0, 3'b000);
        repeat (8) @(posedge clock_i);
        #1;
        chk("extest", 115'(1'b0), 115'(extest));
        chk("pins", core_out, pin_out);
        tk(1'b0, 1'b0, 3'b000);
        ir_load(4'h0);
        chk("pins", {3'b000, q[111:0]}, pin_out);
        end_sim();
    end
endmodule
